// >>> inc/swdc_pkg.sv
// shared constants and types for the single-wire dimming control link
package swdc_pkg;

    // ----------------------------------------------------------------
    // clock
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int CNT_W = 18;

    // ----------------------------------------------------------------
    // decoder timing, in ns as printed
    // ----------------------------------------------------------------
    localparam int T_OFF_NS = 2_500_000;
    localparam int T_DELAY_NS = 140_000;
    localparam int T_DET_NS = 260_000;
    localparam int T_WIN_NS = 1_000_000;
    localparam int T_EOD_H_NS = 350_000;
    localparam int T_PH_MIN_NS = 2_000;
    localparam int T_PH_MAX_NS = 64_000;
    localparam int T_PH_LONG_MAX_NS = 128_000;

    // least times round up, longest times round down
    localparam int OFF_CYC = (T_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int DELAY_CYC = (T_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int DET_CYC = (T_DET_NS + CLK_NS - 1) / CLK_NS;
    localparam int WIN_CYC = T_WIN_NS / CLK_NS;
    localparam int EOD_H_CYC = (T_EOD_H_NS + CLK_NS - 1) / CLK_NS;
    localparam int PH_MIN_CYC = (T_PH_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PH_MAX_CYC = T_PH_MAX_NS / CLK_NS;
    localparam int PH_LONG_MAX_CYC = T_PH_LONG_MAX_NS / CLK_NS;

    // ----------------------------------------------------------------
    // host timing, in ns, chosen with margin inside the limits
    // ----------------------------------------------------------------
    localparam int H_OFF_NS = 3_000_000;
    localparam int H_DELAY_NS = 200_000;
    localparam int H_DET_NS = 300_000;
    localparam int H_DS_NS = 5_000;
    localparam int H_SHORT_NS = 5_000;
    localparam int H_LONG_NS = 15_000;
    localparam int H_EOD_NS = 400_000;
    localparam int H_OFF_CYC = H_OFF_NS / CLK_NS;
    localparam int H_DELAY_CYC = H_DELAY_NS / CLK_NS;
    localparam int H_DET_CYC = H_DET_NS / CLK_NS;
    localparam int H_DS_CYC = H_DS_NS / CLK_NS;
    localparam int H_SHORT_CYC = H_SHORT_NS / CLK_NS;
    localparam int H_LONG_CYC = H_LONG_NS / CLK_NS;
    localparam int H_EOD_CYC = H_EOD_NS / CLK_NS;
    localparam logic [3:0] PWM_STEP_CYC = 4'ha;

    // ----------------------------------------------------------------
    // codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CODE_FULL = 8'hff;
    localparam logic [7:0] CODE_ZERO = 8'h00;
    localparam logic [3:0] WORD_BITS = 4'h8;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        DS_SHUT = 5'h01,
        DS_FIRST_HIGH = 5'h02,
        DS_FIRST_LOW = 5'h04,
        DS_PWM = 5'h08,
        DS_SERIAL = 5'h10
    } swdc_dev_state_t;

    typedef enum logic [9:0] {
        HS_IDLE = 10'h001,
        HS_OFF = 10'h002,
        HS_EN_HIGH = 10'h004,
        HS_EN_LOW = 10'h008,
        HS_START = 10'h010,
        HS_BIT_LOW = 10'h020,
        HS_BIT_HIGH = 10'h040,
        HS_EOD_LOW = 10'h080,
        HS_EOD_HIGH = 10'h100,
        HS_PWM = 10'h200
    } swdc_host_state_t;

    typedef enum logic [2:0] {
        OP_OFF = 3'h0,
        OP_ON = 3'h1,
        OP_SERIAL = 3'h2,
        OP_WRITE = 3'h3,
        OP_PWM = 3'h4
    } swdc_op_t;

endpackage

// >>> inc/swdc_link_if.sv
// control pin between host and dimming decoder
`timescale 1ns/10ps
`default_nettype none
interface swdc_link_if;
    logic ctrl;
    modport dev (input ctrl);
    modport host (output ctrl);
endinterface
`default_nettype wire

// >>> src/swdc_device.sv
// dimming decoder behind the single control pin
// Functional notes
// - shut down after pin low past 2.5ms
// - mode chosen once at enable, PWM default
// - host first high pulse over 140us
// - host then holds low over 260us
// - programming starts inside 1ms window
// - detection passed selects serial mode
// - serial mode kept until shutdown or reset
// - steady high after reset gives full scale
// - PWM mode reference follows pin duty
// - host PWM between 5kHz and 100kHz
// - 8-bit word, 256 linear levels
// - stored code starts at full scale
// - code register, power reset restores default
// - pin shutdown keeps stored code
// - re-entry without new code reuses old
// - pin high/low gives max/zero current outside serial mode
// - host waits 2us before first bit
// - end of data: low 2-64us, high 350us
`timescale 1ns/10ps
`default_nettype none
module swdc_device #(
    parameter int P_OFF_CYC = swdc_pkg::OFF_CYC,
    parameter int P_DELAY_CYC = swdc_pkg::DELAY_CYC,
    parameter int P_DET_CYC = swdc_pkg::DET_CYC,
    parameter int P_WIN_CYC = swdc_pkg::WIN_CYC,
    parameter int P_EOD_H_CYC = swdc_pkg::EOD_H_CYC,
    parameter int P_PH_LONG_MAX_CYC = swdc_pkg::PH_LONG_MAX_CYC
) (
    // clock and power-on reset
    input wire logic i_clk,
    input wire logic i_reset,
    // control pin
    swdc_link_if.dev link,
    // reference and status
    output logic [7:0] o_ref_code,
    output logic o_enabled,
    output logic o_serial_mode,
    output logic o_code_stored,
    output logic o_frame_error
);
    import swdc_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // short phase inside 2..64us
    function automatic logic short_ok(input logic [CNT_W-1:0] len);
        short_ok = (len >= CNT_W'(PH_MIN_CYC)) && (len <= CNT_W'(PH_MAX_CYC));
    endfunction

    // long phase at least twice the short one, inside its ceiling
    function automatic logic long_ok(input logic [CNT_W-1:0] len,
                                     input logic [CNT_W-1:0] ref_len,
                                     input logic [CNT_W-1:0] ceil);
        long_ok = (len >= {ref_len[CNT_W-2:0], 1'b0}) && (len <= ceil);
    endfunction

    localparam logic [CNT_W-1:0] LONG_CEIL = CNT_W'(P_PH_LONG_MAX_CYC);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    swdc_dev_state_t state_q;
    logic lvl_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] win_q;
    logic [CNT_W-1:0] low_len_q;
    logic [7:0] code_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic in_word_q;
    logic prog_ok_q;
    logic rise;
    logic fall;
    logic shut_hit;
    logic bit_zero;
    logic bit_one;
    logic eod_hit;
    logic eod_late;

    // ----------------------------------------------------------------
    // pin edges and phase timing
    // ----------------------------------------------------------------
    assign rise = link.ctrl && !lvl_q;
    assign fall = !link.ctrl && lvl_q;
    // low held past shutdown time
    assign shut_hit = !lvl_q && (cnt_q >= CNT_W'(P_OFF_CYC));

    // level follower and phase length counter, saturating
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            lvl_q <= 1'b0;
            cnt_q <= '0;
        end
        else
        begin
            lvl_q <= link.ctrl;
            if (rise || fall)
                cnt_q <= '0;
            else if (cnt_q != CNT_MAX)
                cnt_q <= cnt_q + 1'b1;
        end
    end

    // detection window, counted from enable
    always_ff @(posedge i_clk)
    begin
        if (i_reset || state_q == DS_SHUT)
            win_q <= '0;
        else if (win_q != CNT_MAX)
            win_q <= win_q + 1'b1;
    end

    // ----------------------------------------------------------------
    // mode selection
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            state_q <= DS_SHUT;
        else if (state_q != DS_SHUT && shut_hit)
            state_q <= DS_SHUT;
        else
        begin
            case (state_q)
                DS_SHUT:
                    if (rise)
                        state_q <= DS_FIRST_HIGH;
                DS_FIRST_HIGH:
                    if (fall)
                    begin
                        // long first high asks for serial; else PWM
                        if (cnt_q >= CNT_W'(P_DELAY_CYC))
                            state_q <= DS_FIRST_LOW;
                        else
                            state_q <= DS_PWM;
                    end
                DS_FIRST_LOW:
                    if (cnt_q >= CNT_W'(P_DET_CYC) && !lvl_q)
                        state_q <= DS_SERIAL;
                    else if (rise)
                        state_q <= DS_PWM;
                DS_PWM:
                    state_q <= DS_PWM;
                DS_SERIAL:
                    state_q <= DS_SERIAL;
                default:
                    state_q <= DS_SHUT;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // serial word decoder
    // ----------------------------------------------------------------
    // low phase then high phase, ratio decides the bit
    assign bit_zero = short_ok(cnt_q)
        && long_ok(low_len_q, cnt_q, LONG_CEIL);
    assign bit_one = short_ok(low_len_q)
        && long_ok(cnt_q, low_len_q, LONG_CEIL);
    // end of data high reached after a full word and a good low
    assign eod_hit = in_word_q && lvl_q && bit_cnt_q == WORD_BITS
        && short_ok(low_len_q)
        && cnt_q >= CNT_W'(P_EOD_H_CYC);
    // high too long for a bit and no valid end of data
    assign eod_late = in_word_q && lvl_q && cnt_q > LONG_CEIL
        && !(bit_cnt_q == WORD_BITS && short_ok(low_len_q));

    // gate for the first word: must start inside the window
    always_ff @(posedge i_clk)
    begin
        if (i_reset || state_q != DS_SERIAL)
            prog_ok_q <= 1'b0;
        else if (fall && win_q < CNT_W'(P_WIN_CYC))
            prog_ok_q <= 1'b1;
    end

    // bit capture, word framing and error flag
    always_ff @(posedge i_clk)
    begin
        if (i_reset || state_q != DS_SERIAL)
        begin
            low_len_q <= '0;
            shift_q <= CODE_ZERO;
            bit_cnt_q <= '0;
            in_word_q <= 1'b0;
            o_frame_error <= 1'b0;
        end
        else
        begin
            o_frame_error <= 1'b0;
            if (rise)
                low_len_q <= cnt_q;
            if (fall && (prog_ok_q || win_q < CNT_W'(P_WIN_CYC)))
            begin
                if (!in_word_q)
                begin
                    // start of a word; the preceding high was the lead-in
                    in_word_q <= 1'b1;
                    bit_cnt_q <= '0;
                end
                else if (bit_cnt_q != WORD_BITS && (bit_zero || bit_one))
                begin
                    shift_q <= {shift_q[6:0], bit_one};
                    bit_cnt_q <= bit_cnt_q + 1'b1;
                end
                else
                begin
                    // bad bit: drop the word, this fall restarts one
                    bit_cnt_q <= '0;
                    o_frame_error <= 1'b1;
                end
            end
            else if (eod_hit)
            begin
                in_word_q <= 1'b0;
                bit_cnt_q <= '0;
            end
            else if (eod_late)
            begin
                in_word_q <= 1'b0;
                bit_cnt_q <= '0;
                o_frame_error <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // stored brightness code
    // ----------------------------------------------------------------
    // only power reset restores it; pin shutdown leaves it alone
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            code_q <= CODE_FULL;
            o_code_stored <= 1'b0;
        end
        else
        begin
            o_code_stored <= 1'b0;
            if (state_q == DS_SERIAL && eod_hit)
            begin
                code_q <= shift_q;
                o_code_stored <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // reference and status outputs
    // ----------------------------------------------------------------
    // serial uses stored code; otherwise pin gates full scale and the
    // analog filter downstream averages it into the duty fraction
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_ref_code <= CODE_ZERO;
            o_enabled <= 1'b0;
            o_serial_mode <= 1'b0;
        end
        else
        begin
            o_enabled <= (state_q != DS_SHUT);
            o_serial_mode <= (state_q == DS_SERIAL);
            if (state_q == DS_SHUT)
                o_ref_code <= CODE_ZERO;
            else if (state_q == DS_SERIAL)
                o_ref_code <= code_q;
            else if (lvl_q)
                o_ref_code <= CODE_FULL;
            else
                o_ref_code <= CODE_ZERO;
        end
    end

endmodule
`default_nettype wire

// >>> src/swdc_host.sv
// host controller that drives the single control pin
`timescale 1ns/10ps
`default_nettype none
module swdc_host #(
    parameter int P_OFF_CYC = swdc_pkg::H_OFF_CYC,
    parameter int P_DELAY_CYC = swdc_pkg::H_DELAY_CYC,
    parameter int P_DET_CYC = swdc_pkg::H_DET_CYC,
    parameter int P_EOD_CYC = swdc_pkg::H_EOD_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // command port
    input wire logic i_cmd_valid,
    input wire swdc_pkg::swdc_op_t i_cmd_op,
    input wire logic [7:0] i_cmd_data,
    output logic o_cmd_ready,
    output logic o_done,
    // control pin
    swdc_link_if.host link
);
    import swdc_pkg::*;

    localparam logic [CNT_W-1:0] SHORT_LD = CNT_W'(H_SHORT_CYC - 1);
    localparam logic [CNT_W-1:0] LONG_LD = CNT_W'(H_LONG_CYC - 1);

    swdc_host_state_t state_q;
    logic pin_q;
    logic [CNT_W-1:0] tmr_q;
    logic [7:0] shift_q;
    logic [3:0] bits_q;
    logic [7:0] duty_q;
    logic [3:0] step_q;
    logic [7:0] phase_q;
    logic take;

    assign o_cmd_ready = (state_q == HS_IDLE) || (state_q == HS_PWM);
    assign take = o_cmd_ready && i_cmd_valid;
    assign link.ctrl = pin_q;

    // ----------------------------------------------------------------
    // pwm timebase: 256 steps of ten cycles
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_reset || state_q != HS_PWM)
        begin
            step_q <= '0;
            phase_q <= '0;
        end
        else if (step_q == PWM_STEP_CYC - 1'b1)
        begin
            step_q <= '0;
            phase_q <= phase_q + 1'b1;
        end
        else
            step_q <= step_q + 1'b1;
    end

    // ----------------------------------------------------------------
    // sequencer: state, timer, pin and word shifter
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state_q <= HS_IDLE;
            pin_q <= 1'b0;
            tmr_q <= '0;
            shift_q <= CODE_ZERO;
            bits_q <= '0;
            duty_q <= CODE_ZERO;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (tmr_q != '0)
                tmr_q <= tmr_q - 1'b1;
            if (take)
            begin
                case (i_cmd_op)
                    OP_OFF:
                    begin
                        pin_q <= 1'b0;
                        tmr_q <= CNT_W'(P_OFF_CYC - 1);
                        state_q <= HS_OFF;
                    end
                    OP_ON:
                    begin
                        pin_q <= 1'b1;
                        state_q <= HS_IDLE;
                        o_done <= 1'b1;
                    end
                    OP_SERIAL:
                    begin
                        pin_q <= 1'b1;
                        tmr_q <= CNT_W'(P_DELAY_CYC - 1);
                        state_q <= HS_EN_HIGH;
                    end
                    OP_WRITE:
                    begin
                        pin_q <= 1'b1;
                        tmr_q <= CNT_W'(H_DS_CYC - 1);
                        shift_q <= i_cmd_data;
                        bits_q <= '0;
                        state_q <= HS_START;
                    end
                    OP_PWM:
                    begin
                        duty_q <= i_cmd_data;
                        pin_q <= 1'b0;
                        state_q <= HS_PWM;
                        o_done <= 1'b1;
                    end
                    default:
                        state_q <= HS_IDLE;
                endcase
            end
            else
            begin
                case (state_q)
                    HS_IDLE:
                        state_q <= HS_IDLE;
                    HS_PWM:
                        pin_q <= (phase_q < duty_q);
                    HS_OFF:
                        if (tmr_q == '0)
                        begin
                            state_q <= HS_IDLE;
                            o_done <= 1'b1;
                        end
                    HS_EN_HIGH:
                        if (tmr_q == '0)
                        begin
                            pin_q <= 1'b0;
                            tmr_q <= CNT_W'(P_DET_CYC - 1);
                            state_q <= HS_EN_LOW;
                        end
                    HS_EN_LOW:
                        if (tmr_q == '0)
                        begin
                            pin_q <= 1'b1;
                            state_q <= HS_IDLE;
                            o_done <= 1'b1;
                        end
                    HS_START:
                        if (tmr_q == '0)
                        begin
                            pin_q <= 1'b0;
                            tmr_q <= shift_q[7] ? SHORT_LD : LONG_LD;
                            state_q <= HS_BIT_LOW;
                        end
                    HS_BIT_LOW:
                        if (tmr_q == '0)
                        begin
                            pin_q <= 1'b1;
                            tmr_q <= shift_q[7] ? LONG_LD : SHORT_LD;
                            state_q <= HS_BIT_HIGH;
                        end
                    HS_BIT_HIGH:
                        if (tmr_q == '0)
                        begin
                            pin_q <= 1'b0;
                            shift_q <= {shift_q[6:0], 1'b0};
                            bits_q <= bits_q + 1'b1;
                            if (bits_q == WORD_BITS - 1'b1)
                            begin
                                tmr_q <= SHORT_LD;
                                state_q <= HS_EOD_LOW;
                            end
                            else
                            begin
                                tmr_q <= shift_q[6] ? SHORT_LD : LONG_LD;
                                state_q <= HS_BIT_LOW;
                            end
                        end
                    HS_EOD_LOW:
                        if (tmr_q == '0)
                        begin
                            pin_q <= 1'b1;
                            tmr_q <= CNT_W'(P_EOD_CYC - 1);
                            state_q <= HS_EOD_HIGH;
                        end
                    HS_EOD_HIGH:
                        if (tmr_q == '0)
                        begin
                            state_q <= HS_IDLE;
                            o_done <= 1'b1;
                        end
                    default:
                        state_q <= HS_IDLE;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// >>> verification/swdc_link_asserts.sv
// concurrent checks on the control pin and the decoder outputs
`timescale 1ns/10ps
`default_nettype none
module swdc_link_asserts #(
    parameter int P_OFF_CYC = 3000,
    parameter int P_DET_CYC = 500
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // pin and decoder outputs
    input wire logic ctrl,
    input wire logic [7:0] o_ref_code,
    input wire logic o_enabled,
    input wire logic o_serial_mode,
    input wire logic o_code_stored,
    input wire logic o_frame_error
);
    logic [19:0] low_cnt_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // consecutive low cycles seen on the pin
    always_ff @(posedge i_clk)
    begin
        if (i_reset || ctrl)
            low_cnt_q <= 20'h0;
        else if (low_cnt_q != 20'hfffff)
            low_cnt_q <= low_cnt_q + 20'h1;
    end
    shut_on_low_a: assert property (
        low_cnt_q == P_OFF_CYC + 4 |-> !o_enabled)
        else $error("no shutdown after long low");
    no_early_shut_a: assert property (
        $fell(o_enabled) |-> low_cnt_q >= P_OFF_CYC - 2)
        else $error("shutdown after short low");
    shut_ref_zero_a: assert property (
        !o_enabled && !$past(o_enabled) |-> o_ref_code == 8'h00)
        else $error("reference not zero in shutdown");
    serial_entry_a: assert property (
        $rose(o_serial_mode) |-> !ctrl && low_cnt_q >= P_DET_CYC - 2)
        else $error("serial mode without detection low");
    serial_sticky_a: assert property (
        $fell(o_serial_mode) |-> !o_enabled)
        else $error("serial mode left while enabled");
    pwm_follow_a: assert property (
        o_enabled && $past(o_enabled, 3) && !o_serial_mode
        && !$past(o_serial_mode) |-> o_ref_code == {8{$past(ctrl, 2)}})
        else $error("reference does not follow pin");
    serial_hold_a: assert property (
        o_serial_mode && $past(o_serial_mode) && $past(o_serial_mode, 2)
        && !$past(o_code_stored) |-> $stable(o_ref_code))
        else $error("serial reference moved without store");
    store_in_serial_a: assert property (
        o_code_stored |-> o_serial_mode && $past(ctrl))
        else $error("store outside serial end of data");
    error_in_serial_a: assert property (
        o_frame_error |-> o_serial_mode ##1 !o_frame_error)
        else $error("frame error outside serial mode");
endmodule
`default_nettype wire

// >>> verification/single_wire_dimming_control_tb.sv
// self-checking bench for host and decoder joined over the control pin
`timescale 1ns/10ps
`default_nettype none
module single_wire_dimming_control_tb;
    import swdc_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic cmd_valid = 1'b0;
    swdc_op_t cmd_op = OP_OFF;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, cmd_done, enabled, serial, stored, frame_err;
    logic [7:0] ref_code, d;
    int num_errors = 0;
    int num_checks = 0;
    int num_stores = 0;
    int num_ferr = 0;
    int wr_q[$];
    int cyc = 0;
    int exp_code, s0, hi;
    // shortened decoder timing for simulation
    localparam int DEV_OFF = 3000;
    localparam int DEV_DLY = 2600;
    localparam int DEV_DET = 500;
    localparam int DEV_WIN = 4000;
    localparam int DEV_EOD = 1000;
    localparam int DEV_LONG = 800;
    // host timing, each above the decoder threshold it must pass
    localparam int HST_OFF = 4000;
    localparam int HST_DLY = 2700;
    localparam int HST_DET = 600;
    localparam int HST_EOD = 1200;
    swdc_link_if swdc_link_if_inst ();
    swdc_device #(.P_OFF_CYC(DEV_OFF), .P_DELAY_CYC(DEV_DLY),
        .P_DET_CYC(DEV_DET), .P_WIN_CYC(DEV_WIN), .P_EOD_H_CYC(DEV_EOD),
        .P_PH_LONG_MAX_CYC(DEV_LONG))
    swdc_device_inst (.i_clk(i_clk), .i_reset(i_reset),
        .link(swdc_link_if_inst.dev), .o_ref_code(ref_code),
        .o_enabled(enabled), .o_serial_mode(serial),
        .o_code_stored(stored), .o_frame_error(frame_err));
    swdc_host #(.P_OFF_CYC(HST_OFF), .P_DELAY_CYC(HST_DLY),
        .P_DET_CYC(HST_DET), .P_EOD_CYC(HST_EOD))
    swdc_host_inst (.i_clk(i_clk), .i_reset(i_reset),
        .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_data(cmd_data),
        .o_cmd_ready(cmd_ready), .o_done(cmd_done),
        .link(swdc_link_if_inst.host));
    swdc_link_asserts #(.P_OFF_CYC(DEV_OFF), .P_DET_CYC(DEV_DET))
    swdc_link_asserts_inst (.i_clk(i_clk), .i_reset(i_reset),
        .ctrl(swdc_link_if_inst.ctrl), .o_ref_code(ref_code),
        .o_enabled(enabled), .o_serial_mode(serial),
        .o_code_stored(stored), .o_frame_error(frame_err));
    // 50 MHz clock
    initial
    begin
        forever #10 i_clk = ~i_clk;
    end
    // store pulses and hang guard
    always @(posedge i_clk)
    begin
        cyc++;
        if (stored === 1'b1)
            num_stores++;
        if (frame_err === 1'b1)
            num_ferr++;
        if (cyc == 95000)
        begin
            num_errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // one host command, waits for its completion pulse
    task automatic cmd(input swdc_op_t op, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge i_clk);
        while (cmd_ready !== 1'b1)
            @(posedge i_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_data <= v;
        @(posedge i_clk);
        cmd_valid <= 1'b0;
        #1;
        while (cmd_done !== 1'b1 && n < 20000)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("done", 8'h01, {7'h0, cmd_done});
    endtask
    // main sequence
    initial
    begin
        void'($urandom(32'h03105d14));
        exp_code = 255;
        tick(2);
        @(posedge i_clk) i_reset <= 1'b0;
        cmd(OP_ON, 8'h00);
        tick(10);
        chk("ref_on", 8'hff, ref_code);
        chk("pwm_mode", 8'h00, {7'h0, serial});
        $display("test 1 done");
        cmd(OP_OFF, 8'h00);
        tick(5);
        chk("enabled", 8'h00, {7'h0, enabled});
        chk("ref_off", 8'h00, ref_code);
        $display("test 2 done");
        cmd(OP_SERIAL, 8'h00);
        tick(5);
        chk("serial", 8'h01, {7'h0, serial});
        chk("ref_default", 8'(exp_code), ref_code);
        d = 8'($urandom);
        s0 = num_stores;
        cmd(OP_WRITE, d);
        wr_q.push_back(d);
        exp_code = wr_q[$];
        chk("ref_write", 8'(exp_code), ref_code);
        chk("stores", 8'h01, 8'(num_stores - s0));
        chk("no_ferr", 8'h00, 8'(num_ferr));
        $display("test 3 done");
        cmd(OP_OFF, 8'h00);
        chk("serial_off", 8'h00, {7'h0, serial});
        cmd(OP_SERIAL, 8'h00);
        tick(5);
        chk("ref_kept", 8'(exp_code), ref_code);
        // pulses inside the window with highs too long for a bit
        cmd(OP_PWM, 8'h80);
        tick(1500);
        chk("frame_err", 8'h01, 8'(num_ferr > 0));
        chk("serial_kept", 8'h01, {7'h0, serial});
        chk("ref_bad", 8'(exp_code), ref_code);
        $display("test 4 done");
        cmd(OP_OFF, 8'h00);
        cmd(OP_SERIAL, 8'h00);
        tick(4100);
        s0 = num_stores;
        cmd(OP_WRITE, ~d);
        chk("ref_late", 8'(exp_code), ref_code);
        chk("late_stores", 8'h00, 8'(num_stores - s0));
        $display("test 5 done");
        cmd(OP_OFF, 8'h00);
        d = 8'($urandom_range(1, 254));
        cmd(OP_PWM, d);
        tick(5120);
        hi = 0;
        repeat (2560)
        begin
            tick(1);
            if (ref_code === 8'hff)
                hi++;
        end
        chk("pwm_duty", 8'h01,
            {7'h0, hi >= d * 10 - 4 && hi <= d * 10 + 4});
        chk("pwm_on", 8'h01, {7'h0, enabled});
        chk("pwm_sel", 8'h00, {7'h0, serial});
        $display("test 6 done");
        @(posedge i_clk) i_reset <= 1'b1;
        tick(2);
        @(posedge i_clk) i_reset <= 1'b0;
        wr_q.delete();
        exp_code = 255;
        cmd(OP_SERIAL, 8'h00);
        tick(5);
        chk("ref_reset", 8'(exp_code), ref_code);
        $display("test 7 done");
        conclude();
    end
endmodule
`default_nettype wire
